// ### rtl/ltc_axis.sv
// one raster axis: sync pulse, back porch, active, front porch, repeating
// assumes adv is a one-cycle step and run low parks it at the pulse start
`timescale 1ns/1ps
`default_nettype none
module ltc_axis #(
	parameter int W = 11,
	parameter int TW = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic adv,
	input wire logic run,
	input wire logic [TW-1:0] pw,
	input wire logic [TW-1:0] bp,
	input wire logic [TW-1:0] fp,
	input wire logic [W-1:0] act,
	ltc_axis_if.cnt ax
);
	typedef enum {SEG_PULSE, SEG_BACK, SEG_ACTIVE, SEG_FRONT} ltc_seg_t;

	ltc_seg_t seg_q;    // current segment
	logic [W-1:0] cnt_q; // steps spent in it
	logic [W-1:0] len;  // length of the current segment
	logic last;         // this step ends the segment

	// ------------------------------------------------------------
	// segment length; zero behaves as one so the axis never stalls
	// ------------------------------------------------------------
	always_comb begin
		case (seg_q)
			SEG_PULSE: len = W'(pw);
			SEG_BACK: len = W'(bp);
			SEG_ACTIVE: len = act;
			SEG_FRONT: len = W'(fp);
			default: len = '0;
		endcase
		last = (len <= W'(1)) || (cnt_q == len - W'(1));
	end

	// ------------------------------------------------------------
	// pulse, back porch, active, front porch, then again
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seg_q <= SEG_PULSE;
			cnt_q <= '0;
		end else if (!run) begin
			seg_q <= SEG_PULSE; // idle raster restarts cleanly
			cnt_q <= '0;
		end else if (adv && last) begin
			cnt_q <= '0;
			case (seg_q)
				SEG_PULSE: seg_q <= SEG_BACK;
				SEG_BACK: seg_q <= SEG_ACTIVE;
				SEG_ACTIVE: seg_q <= SEG_FRONT;
				SEG_FRONT: seg_q <= SEG_PULSE;
				default: seg_q <= SEG_PULSE;
			endcase
		end else if (adv) begin
			cnt_q <= cnt_q + W'(1);
		end
	end

	assign ax.sync = run && (seg_q == SEG_PULSE);
	assign ax.active = run && (seg_q == SEG_ACTIVE);
	assign ax.at_end = run && (seg_q == SEG_FRONT) && last;
	assign ax.pos = cnt_q;
endmodule : ltc_axis
`default_nettype wire

// ### rtl/ltc_axis_if.sv
// one axis of the raster sequence: sync, active and position
// assumes the counter and its reader share one clock
`timescale 1ns/1ps
`default_nettype none
interface ltc_axis_if #(parameter int W = 11);
	logic sync;        // inside the sync pulse
	logic active;      // inside the active region
	logic at_end;      // last step of the front porch
	logic [W-1:0] pos; // step count inside the current segment
	modport cnt (output sync, output active, output at_end, output pos);
	modport snk (input sync, input active, input at_end, input pos);
endinterface : ltc_axis_if
`default_nettype wire

// ### rtl/ltc_pixdiv.sv
// pixel rate divider: one-cycle enable and a half-period phase level
// assumes div of two or more for a visible clock
`timescale 1ns/1ps
`default_nettype none
module ltc_pixdiv #(
	parameter int DIV = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	output logic pix_en,
	output logic phase_hi
);
	localparam int PW = (DIV > 1) ? $clog2(DIV) : 1;

	logic [PW-1:0] ph_q; // position inside one pixel period

	// ------------------------------------------------------------
	// free-running phase count, so the pixel clock runs before raster
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q <= '0;
		end else if (ph_q == PW'(DIV - 1)) begin
			ph_q <= '0;
		end else begin
			ph_q <= ph_q + PW'(1);
		end
	end

	assign pix_en = (ph_q == PW'(DIV - 1));
	assign phase_hi = (ph_q >= PW'(DIV / 2));
endmodule : ltc_pixdiv
`default_nettype wire

// ### rtl/ltc_pkg.sv
// constants of the lcd raster timing block: register map, fields, resets
// assumes a 32-bit apb slave and one system clock of 20 MHz
package ltc_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADR_MODE = 8'h00;   // operating mode and raster enable
	localparam logic [7:0] ADR_UPDATE = 8'h04; // transfer request and auto update
	localparam logic [7:0] ADR_POL = 8'h08;    // sync_polarity_ctrl
	localparam logic [7:0] ADR_SIZE = 8'h0c;   // active size
	localparam logic [7:0] ADR_HTIM = 8'h10;   // horizontal_timing_params
	localparam logic [7:0] ADR_VTIM = 8'h14;   // vertical timing params
	localparam logic [7:0] ADR_BACKGROUND_COLOR = 8'h18;   // background_color
	localparam logic [7:0] ADR_STATUS = 8'h1c; // read-only state
	localparam logic [2:0] ADR_BAR_PAGE = 3'h1; // test_bar_color 0x20..0x3c

	// ------------------------------------------------------------
	// field positions and widths
	// ------------------------------------------------------------
	localparam int MODE_LSB = 0;
	localparam int RASTER_BIT = 2;
	localparam int UPD_REQ_BIT = 0;
	localparam int UPD_AUTO_BIT = 1;
	localparam int POL_PCLK_BIT = 0;
	localparam int POL_HS_BIT = 1;
	localparam int POL_VS_BIT = 2;
	localparam int VRES_LSB = 0;
	localparam int VRES_W = 11;
	localparam int HRES_LSB = 16;
	localparam int HRES_W = 7;
	localparam int H_UNIT_SHIFT = 4;  // width field counts units of 16 pixels
	localparam int TIM_W = 10;
	localparam int TIM_PW_LSB = 0;
	localparam int TIM_BP_LSB = 10;
	localparam int TIM_FP_LSB = 20;
	localparam int POS_W = 11;
	localparam int RGB_W = 24;
	localparam int BAR_COUNT = 8;
	localparam int BAR_SHIFT = 3;     // log2 of the bar count

	// ------------------------------------------------------------
	// modes and reset values
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LTC_MODE_OFF = 2'h0,
		LTC_MODE_NORMAL = 2'h1,
		LTC_MODE_RSVD = 2'h2,
		LTC_MODE_BARS = 2'h3
	} ltc_mode_t;

	localparam logic [23:0] RST_BACKGROUND_COLOR = 24'h000000;
	localparam logic [31:0] RST_TIMING = 32'h00000000;
	// left black, then blue, red, magenta, green, cyan, yellow, right white
	localparam logic [7:0][23:0] RST_BARS = {
		24'hffffff, 24'hffff00, 24'h00ffff, 24'h00ff00,
		24'hff00ff, 24'hff0000, 24'h0000ff, 24'h000000
	};

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int PCLK_PERIOD_NS = 400;
	localparam int PCLK_DIV = PCLK_PERIOD_NS / CLK_PERIOD_NS;

endpackage : ltc_pkg

// ### rtl/ltc_raster_top.sv
// lcd raster timing generator with test card, apb registers and panel pins
// assumes an apb master on CLOCK and a parallel rgb panel on the lcd pins;
// the overlay inputs come from a composer on the same clock
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - vsync lasts programmed pulse lines
// - back porch lines follow vsync pulse
// - front porch lines precede next vsync
// - data enable only on active lines
// - separate polarity for pclk, hsync, vsync
// - timing, size, colour and polarity writes act only after a transfer
// - request bit starts transfer, self clears
// - auto mode transfers once per frame
// - mode three selects colour bars
// - raster enable gates syncs and data
// - pixel clock may run before raster
// - colour bars split line in eight
// - bar n uses colour register n
// - bar registers hold writable rgb888
// - mode one selects normal display
// - normal mode shows background, resets black
// - overlay content drawn over background
// - horizontal pulse, porches counted in pixels
// - width field is pixels divided by sixteen
module ltc_raster_top #(
	parameter int PCLK_DIV = ltc_pkg::PCLK_DIV
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic OVL_VALID,
	input wire logic [23:0] OVL_RGB,
	output logic LCD_PCLK,
	output logic LCD_HSYNC,
	output logic LCD_VSYNC,
	output logic LCD_DE,
	output logic [23:0] LCD_RGB
);
	localparam int TW = ltc_pkg::TIM_W;
	localparam int PW = ltc_pkg::POS_W;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic rst_meta_q;   // first reset release stage
	logic rst_n_q;      // released reset used everywhere
	logic rst_n;

	// control, acts at once
	logic [1:0] mode_q;    // operating_mode_field
	logic raster_q;        // raster enable
	logic req_q;           // transfer_request_bit
	logic auto_q;          // per-frame automatic transfer

	// software-facing copies
	logic [2:0] pol_sh_q;
	logic [ltc_pkg::VRES_W-1:0] vres_sh_q;
	logic [ltc_pkg::HRES_W-1:0] hres_sh_q;
	logic [3*TW-1:0] htim_sh_q;
	logic [3*TW-1:0] vtim_sh_q;
	logic [23:0] background_color_sh_q;
	logic [7:0][23:0] bar_sh_q;

	// working state, what the raster really uses
	logic loaded_q;        // at least one transfer done
	logic [2:0] pol_q;
	logic [ltc_pkg::VRES_W-1:0] vres_q;
	logic [ltc_pkg::HRES_W-1:0] hres_q;
	logic [3*TW-1:0] htim_q;
	logic [3*TW-1:0] vtim_q;
	logic [23:0] background_color_q;
	logic [7:0][23:0] bar_q;

	// bus decode
	logic wr;              // write takes effect this edge
	logic setup;           // setup phase, read data captured
	logic is_bar;          // address falls on a bar register
	logic [2:0] bar_sel;   // which bar register
	logic mapped;          // address decodes to a register
	logic [31:0] rd_d;     // read value for the captured address
	logic [31:0] prdata_q;

	// raster
	logic pix_en;          // one pulse per pixel period
	logic phase_hi;        // second half of the pixel period
	logic run;             // raster is producing frames
	logic copy;            // working state loads this cycle
	logic frame_end;       // last pixel of the last front porch line
	logic line_adv;        // one pulse per line
	logic in_act;          // current pixel is valid
	logic [PW-1:0] act_h;  // active pixels per line
	logic [PW-1:0] bar_w;  // pixels per bar
	logic [PW-1:0] bar_px_q;
	logic [2:0] bar_idx_q;
	logic [23:0] pix;      // colour of the current pixel
	logic pclk_q;
	logic hs_q;
	logic vs_q;
	logic de_q;
	logic [23:0] rgb_q;

	ltc_axis_if #(.W(PW)) h_ax ();
	ltc_axis_if #(.W(PW)) v_ax ();

	// ------------------------------------------------------------
	// reset release through two flip-flops
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end
	assign rst_n = rst_n_q;

	// ------------------------------------------------------------
	// apb decode, zero wait states
	// ------------------------------------------------------------
	assign wr = PSEL && PENABLE && PWRITE;
	assign setup = PSEL && !PENABLE;
	assign is_bar = (PADDR[7:5] == ltc_pkg::ADR_BAR_PAGE) && (PADDR[1:0] == 2'h0);
	assign bar_sel = PADDR[4:2];
	assign mapped = is_bar || (PADDR == ltc_pkg::ADR_MODE) || (PADDR == ltc_pkg::ADR_UPDATE)
		|| (PADDR == ltc_pkg::ADR_POL) || (PADDR == ltc_pkg::ADR_SIZE)
		|| (PADDR == ltc_pkg::ADR_HTIM) || (PADDR == ltc_pkg::ADR_VTIM)
		|| (PADDR == ltc_pkg::ADR_BACKGROUND_COLOR) || (PADDR == ltc_pkg::ADR_STATUS);
	assign PREADY = PSEL && PENABLE;
	assign PSLVERR = PSEL && PENABLE && !mapped; // unmapped: error, write dropped

	// ------------------------------------------------------------
	// read mux; configuration reads show the software copies, not working state
	// ------------------------------------------------------------
	always_comb begin
		rd_d = 32'h00000000;
		if (is_bar) begin
			rd_d[23:0] = bar_sh_q[bar_sel];
		end else begin
			case (PADDR)
				ltc_pkg::ADR_MODE: begin
					rd_d[ltc_pkg::MODE_LSB +: 2] = mode_q;
					rd_d[ltc_pkg::RASTER_BIT] = raster_q;
				end
				ltc_pkg::ADR_UPDATE: begin
					rd_d[ltc_pkg::UPD_REQ_BIT] = req_q;
					rd_d[ltc_pkg::UPD_AUTO_BIT] = auto_q;
				end
				ltc_pkg::ADR_POL: rd_d[2:0] = pol_sh_q;
				ltc_pkg::ADR_SIZE: begin
					rd_d[ltc_pkg::VRES_LSB +: ltc_pkg::VRES_W] = vres_sh_q;
					rd_d[ltc_pkg::HRES_LSB +: ltc_pkg::HRES_W] = hres_sh_q;
				end
				ltc_pkg::ADR_HTIM: rd_d[3*TW-1:0] = htim_sh_q;
				ltc_pkg::ADR_VTIM: rd_d[3*TW-1:0] = vtim_sh_q;
				ltc_pkg::ADR_BACKGROUND_COLOR: rd_d[23:0] = background_color_sh_q;
				ltc_pkg::ADR_STATUS: begin
					rd_d[0] = loaded_q;
					rd_d[1] = run;
					rd_d[2] = v_ax.sync;
					rd_d[3] = in_act;
				end
				default: rd_d = 32'h00000000;
			endcase
		end
	end

	// captured in the setup phase so prdata comes from a flip-flop
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= 32'h00000000;
		end else if (setup && !PWRITE) begin
			prdata_q <= rd_d;
		end
	end
	assign PRDATA = prdata_q;

	// ------------------------------------------------------------
	// mode and raster enable: one write may set both together
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= ltc_pkg::LTC_MODE_OFF;
			raster_q <= 1'b0;
		end else if (wr && PADDR == ltc_pkg::ADR_MODE) begin
			mode_q <= PWDATA[ltc_pkg::MODE_LSB +: 2];
			raster_q <= PWDATA[ltc_pkg::RASTER_BIT];
		end
	end

	// ------------------------------------------------------------
	// transfer request and auto mode; a new request wins over the clear
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			req_q <= 1'b0;
			auto_q <= 1'b0;
		end else begin
			if (wr && PADDR == ltc_pkg::ADR_UPDATE) begin
				auto_q <= PWDATA[ltc_pkg::UPD_AUTO_BIT];
			end
			if (wr && PADDR == ltc_pkg::ADR_UPDATE && PWDATA[ltc_pkg::UPD_REQ_BIT]) begin
				req_q <= 1'b1;
			end else if (copy) begin
				req_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// software copies of the configuration
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			pol_sh_q <= 3'h0;
			vres_sh_q <= ltc_pkg::RST_TIMING[ltc_pkg::VRES_LSB +: ltc_pkg::VRES_W];
			hres_sh_q <= ltc_pkg::RST_TIMING[ltc_pkg::HRES_LSB +: ltc_pkg::HRES_W];
			htim_sh_q <= ltc_pkg::RST_TIMING[3*TW-1:0];
			vtim_sh_q <= ltc_pkg::RST_TIMING[3*TW-1:0];
			background_color_sh_q <= ltc_pkg::RST_BACKGROUND_COLOR;
			bar_sh_q <= ltc_pkg::RST_BARS;
		end else if (wr && is_bar) begin
			bar_sh_q[bar_sel] <= PWDATA[23:0];
		end else if (wr) begin
			case (PADDR)
				ltc_pkg::ADR_POL: pol_sh_q <= PWDATA[2:0];
				ltc_pkg::ADR_SIZE: begin
					vres_sh_q <= PWDATA[ltc_pkg::VRES_LSB +: ltc_pkg::VRES_W];
					hres_sh_q <= PWDATA[ltc_pkg::HRES_LSB +: ltc_pkg::HRES_W];
				end
				ltc_pkg::ADR_HTIM: htim_sh_q <= PWDATA[3*TW-1:0];
				ltc_pkg::ADR_VTIM: vtim_sh_q <= PWDATA[3*TW-1:0];
				ltc_pkg::ADR_BACKGROUND_COLOR: background_color_sh_q <= PWDATA[23:0];
				default: pol_sh_q <= pol_sh_q;
			endcase
		end
	end

	// ------------------------------------------------------------
	// transfer point: at once when idle, else at the frame boundary so a
	// frame never mixes two configurations
	// ------------------------------------------------------------
	assign copy = (req_q && (!run || frame_end))
		|| (auto_q && loaded_q && frame_end);

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			loaded_q <= 1'b0;
			pol_q <= 3'h0;
			vres_q <= '0;
			hres_q <= '0;
			htim_q <= '0;
			vtim_q <= '0;
			background_color_q <= ltc_pkg::RST_BACKGROUND_COLOR;
			bar_q <= ltc_pkg::RST_BARS;
		end else if (copy) begin
			loaded_q <= 1'b1;
			pol_q <= pol_sh_q;
			vres_q <= vres_sh_q;
			hres_q <= hres_sh_q;
			htim_q <= htim_sh_q;
			vtim_q <= vtim_sh_q;
			background_color_q <= background_color_sh_q;
			bar_q <= bar_sh_q;
		end
	end

	// ------------------------------------------------------------
	// timing chain: pixel divider, line axis, frame axis
	// ------------------------------------------------------------
	assign run = raster_q && loaded_q
		&& (mode_q == ltc_pkg::LTC_MODE_NORMAL || mode_q == ltc_pkg::LTC_MODE_BARS);
	assign act_h = PW'(hres_q) << ltc_pkg::H_UNIT_SHIFT;
	assign line_adv = pix_en && h_ax.at_end;
	assign frame_end = line_adv && v_ax.at_end;

	ltc_pixdiv #(.DIV(PCLK_DIV)) u_div (
		.clk(CLOCK),
		.rst_n(rst_n),
		.pix_en(pix_en),
		.phase_hi(phase_hi)
	);

	ltc_axis #(.W(PW), .TW(TW)) u_hax (
		.clk(CLOCK),
		.rst_n(rst_n),
		.adv(pix_en),
		.run(run),
		.pw(htim_q[ltc_pkg::TIM_PW_LSB +: TW]),
		.bp(htim_q[ltc_pkg::TIM_BP_LSB +: TW]),
		.fp(htim_q[ltc_pkg::TIM_FP_LSB +: TW]),
		.act(act_h),
		.ax(h_ax.cnt)
	);

	ltc_axis #(.W(PW), .TW(TW)) u_vax (
		.clk(CLOCK),
		.rst_n(rst_n),
		.adv(line_adv),
		.run(run),
		.pw(vtim_q[ltc_pkg::TIM_PW_LSB +: TW]),
		.bp(vtim_q[ltc_pkg::TIM_BP_LSB +: TW]),
		.fp(vtim_q[ltc_pkg::TIM_FP_LSB +: TW]),
		.act(PW'(vres_q)),
		.ax(v_ax.cnt)
	);

	assign in_act = h_ax.active && v_ax.active;

	// ------------------------------------------------------------
	// bar position: counted, not divided, to keep the path short
	// ------------------------------------------------------------
	assign bar_w = act_h >> ltc_pkg::BAR_SHIFT;

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			bar_px_q <= '0;
			bar_idx_q <= 3'h0;
		end else if (pix_en && in_act) begin
			if (bar_w == '0 || bar_px_q == bar_w - PW'(1)) begin
				bar_px_q <= '0;
				bar_idx_q <= bar_idx_q + 3'h1;
			end else begin
				bar_px_q <= bar_px_q + PW'(1);
			end
		end else if (pix_en) begin
			bar_px_q <= '0;                              // every line starts at bar 0
			bar_idx_q <= 3'h0;
		end
	end

	// ------------------------------------------------------------
	// pixel source by mode
	// ------------------------------------------------------------
	always_comb begin
		case (mode_q)
			ltc_pkg::LTC_MODE_BARS: pix = bar_q[bar_idx_q];
			ltc_pkg::LTC_MODE_NORMAL: pix = OVL_VALID ? OVL_RGB
				: background_color_q;
			default: pix = 24'h000000;
		endcase
	end

	// ------------------------------------------------------------
	// panel pins; all raster pins change together on the pixel pulse
	// ------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			hs_q <= 1'b0;
			vs_q <= 1'b0;
			de_q <= 1'b0;
			rgb_q <= 24'h000000;
		end else if (pix_en) begin
			hs_q <= h_ax.sync ^ pol_q[ltc_pkg::POL_HS_BIT];
			vs_q <= v_ax.sync ^ pol_q[ltc_pkg::POL_VS_BIT];
			de_q <= in_act;
			rgb_q <= in_act ? pix : 24'h000000;
		end
	end

	// clock runs once configured, whatever raster enable says
	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			pclk_q <= 1'b0;
		end else begin
			pclk_q <= (loaded_q && phase_hi) ^ pol_q[ltc_pkg::POL_PCLK_BIT];
		end
	end

	assign LCD_PCLK = pclk_q;
	assign LCD_HSYNC = hs_q;
	assign LCD_VSYNC = vs_q;
	assign LCD_DE = de_q;
	assign LCD_RGB = rgb_q;
endmodule : ltc_raster_top
`default_nettype wire

// ### test/ltc_panel_model.sv
// parallel rgb panel: takes one pixel per rising pixel clock with de high
// assumes pixel clock polarity at its reset value while pixels flow
`timescale 1ns/1ps
`default_nettype none
module ltc_panel_model (
	input wire logic pclk,
	input wire logic de,
	input wire logic [23:0] rgb,
	output logic tick,
	output logic [23:0] px
);
	// ------------------------------------------------------------
	// pixel capture
	// ------------------------------------------------------------
	initial tick = 1'b0;
	// tick toggles so the bench sees every accepted pixel as an event
	always @(posedge pclk) begin
		if (de) begin
			px <= rgb;
			tick <= ~tick;
		end
	end
endmodule : ltc_panel_model
`default_nettype wire

// ### test/ltc_raster_chk.sv
// raster block checker on the top-level ports
// assumes one clock domain and the raw async reset
`timescale 1ns/1ps
`default_nettype none
module ltc_raster_chk #(
	parameter int PCLK_DIV = 8
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic [7:0] PADDR,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic LCD_PCLK,
	input wire logic LCD_HSYNC,
	input wire logic LCD_VSYNC,
	input wire logic LCD_DE,
	input wire logic [23:0] LCD_RGB
);
	// ------------------------------------------------------------
	// bus and raster properties
	// ------------------------------------------------------------
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	chk_ready_access: assert property (PSEL && PENABLE |-> PREADY)
		else $error("access cycle without ready");
	chk_err_mapped: assert property (PSEL && PENABLE && PADDR < 8'h40 && PADDR[1:0] == 2'h0
		|-> !PSLVERR)
		else $error("error on a mapped address");
	chk_err_unmapped: assert property (PSEL && PENABLE && PADDR >= 8'h40 |-> PSLVERR)
		else $error("no error on an unmapped address");
	chk_quiet_reset: assert property ($rose(RST_N) |=> (!LCD_PCLK && !LCD_DE) [*8])
		else $error("raster moved before any transfer");
	chk_de_no_sync: assert property (LCD_DE |-> !LCD_HSYNC && !LCD_VSYNC)
		else $error("data enable inside a sync pulse");
	chk_de_on_pclk: assert property ($rose(LCD_DE) |=> $changed(LCD_PCLK))
		else $error("data enable off the pixel clock");
	chk_de_run: assert property ($rose(LCD_DE) |-> LCD_DE [*8])
		else $error("active run too short");
	chk_rgb_first_hold: assert property ($rose(LCD_DE) |=> $stable(LCD_RGB) [*2])
		else $error("first pixel not held");
	// main scenarios reached
	cover property ($rose(LCD_DE));
	cover property (PSLVERR);
	cover property ($rose(LCD_PCLK));
endmodule : ltc_raster_chk
bind ltc_raster_top ltc_raster_chk #(.PCLK_DIV(PCLK_DIV)) ltc_raster_chk_inst (
	.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .LCD_PCLK(LCD_PCLK), .LCD_HSYNC(LCD_HSYNC),
	.LCD_VSYNC(LCD_VSYNC), .LCD_DE(LCD_DE), .LCD_RGB(LCD_RGB));
`default_nettype wire

// ### test/tb_lcd_raster_timing_testcard.sv
// bench: register reads, bar card, background, overlay, sync polarity
// assumes the panel model toggles tick once per accepted pixel
`timescale 1ns/1ps
`default_nettype none
module tb_lcd_raster_timing_testcard;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic CLOCK = 1'b0;
	logic RST_N = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic OVL_VALID = 1'b0;
	logic [23:0] OVL_RGB = 24'h0;
	logic [31:0] PRDATA, rd;
	logic PREADY, PSLVERR, serr, LCD_PCLK, LCD_HSYNC, LCD_VSYNC, LCD_DE, tick, pk;
	logic [23:0] LCD_RGB, px, got, bg;
	logic [23:0] bars [8];
	logic [23:0] expq [$]; // expected pixels, oldest first
	int err_total = 0;
	int total_checks = 0;
	always #25 CLOCK = ~CLOCK;
	// pixel clock of 400 ns, the divider's default
	ltc_raster_top #(.PCLK_DIV(ltc_pkg::PCLK_DIV)) ltc_raster_top_inst (
		.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .OVL_VALID(OVL_VALID), .OVL_RGB(OVL_RGB),
		.LCD_PCLK(LCD_PCLK), .LCD_HSYNC(LCD_HSYNC), .LCD_VSYNC(LCD_VSYNC),
		.LCD_DE(LCD_DE), .LCD_RGB(LCD_RGB));
	ltc_panel_model ltc_panel_model_inst (
		.pclk(LCD_PCLK), .de(LCD_DE), .rgb(LCD_RGB), .tick(tick), .px(px));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task summarize;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	task fail_out;
		err_total++;
		summarize();
	endtask : fail_out
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// one apb transfer; request held until ready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge CLOCK);
			if (PREADY === 1'b1) break;
		end
		if (n == 50) fail_out();
		rd = PRDATA;
		serr = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLOCK);
	endtask : apb
	// request a copy and poll until the request bit drops
	task xfer;
		int n;
		apb(1'b1, ltc_pkg::ADR_UPDATE, 32'h1);
		for (n = 0; n < 200; n++) begin
			apb(1'b0, ltc_pkg::ADR_UPDATE, 32'h0);
			if (rd[0] === 1'b0) break;
		end
		if (n == 200) fail_out();
		chk("request bit", 32'h0, {31'h0, rd[0]});
	endtask : xfer
	// wait until the panel has taken every expected pixel
	task drain;
		int n;
		for (n = 0; n < 5000 && expq.size() > 0; n++) @(posedge CLOCK);
		if (n == 5000) fail_out();
	endtask : drain
	// ------------------------------------------------------------
	// pixel checker: oldest expectation against each panel pixel
	// ------------------------------------------------------------
	always @(tick) begin
		if (expq.size() > 0) begin
			got = expq.pop_front();
			chk("pixel", {8'h0, got}, {8'h0, px});
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int i;
		void'($urandom(32'hcd60788c));
		repeat (20) @(posedge CLOCK);
		RST_N <= 1'b1;
		repeat (3) @(posedge CLOCK);
		apb(1'b0, ltc_pkg::ADR_BACKGROUND_COLOR, 32'h0);
		chk("background_color reset", 32'h0, rd);
		for (i = 0; i < 8; i++) begin
			apb(1'b0, 8'h20 + 8'(i * 4), 32'h0);
			chk("bar reset", {8'h0, ltc_pkg::RST_BARS[i]}, rd);
		end
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, serr});
		for (i = 0; i < 8; i++) begin
			bars[i] = 24'($urandom);
			apb(1'b1, 8'h20 + 8'(i * 4), {8'hff, bars[i]});
		end
		apb(1'b0, 8'h3c, 32'h0);
		chk("bar readback", {8'h0, bars[7]}, rd);
		// 16 pixels, 2 lines, porches of 2 pixels and 1 line
		apb(1'b1, ltc_pkg::ADR_SIZE, 32'h00010002);
		apb(1'b1, ltc_pkg::ADR_HTIM, 32'h00200802);
		apb(1'b1, ltc_pkg::ADR_VTIM, 32'h00100401);
		apb(1'b1, ltc_pkg::ADR_POL, 32'h0);
		apb(1'b1, ltc_pkg::ADR_MODE, 32'h7);
		repeat (40) @(posedge CLOCK);
		chk("idle before copy", 32'h0, {31'h0, LCD_PCLK | LCD_DE});
		for (i = 0; i < 32; i++) expq.push_back(bars[(i % 16) / 2]);
		xfer();
		drain();
		// background, then overlay on top of it
		for (i = 0; i < 2; i++) begin
			apb(1'b1, ltc_pkg::ADR_MODE, 32'h0);
			bg = 24'($urandom);
			if (i == 0) apb(1'b1, ltc_pkg::ADR_BACKGROUND_COLOR, {8'h0, bg});
			else OVL_RGB <= bg;
			OVL_VALID <= (i == 1);
			xfer();
			repeat (32) expq.push_back(bg);
			apb(1'b1, ltc_pkg::ADR_MODE, 32'h5);
			drain();
		end
		// auto transfer: a new colour shows from the next whole frame on
		OVL_VALID <= 1'b0;
		bg = 24'($urandom);
		apb(1'b1, ltc_pkg::ADR_UPDATE, 32'h2);
		apb(1'b1, ltc_pkg::ADR_BACKGROUND_COLOR, {8'h0, bg});
		// skip the frame that may still carry the old colour
		for (i = 0; i < 3000 && LCD_VSYNC !== 1'b1; i++) @(posedge CLOCK);
		for (i = 0; i < 3000 && LCD_VSYNC !== 1'b0; i++) @(posedge CLOCK);
		for (i = 0; i < 3000 && LCD_VSYNC !== 1'b1; i++) @(posedge CLOCK);
		if (i == 3000) fail_out();
		repeat (32) expq.push_back(bg);
		drain();
		apb(1'b1, ltc_pkg::ADR_MODE, 32'h0);
		apb(1'b1, ltc_pkg::ADR_POL, 32'h7);
		xfer();
		// pins only follow the new polarity at the next pixel pulse
		repeat (16) @(posedge CLOCK);
		chk("hsync idle", 32'h1, {31'h0, LCD_HSYNC});
		chk("vsync idle", 32'h1, {31'h0, LCD_VSYNC});
		chk("de idle", 32'h0, {31'h0, LCD_DE});
		// pixel clock keeps running with raster off, half a period apart
		pk = LCD_PCLK;
		repeat (4) @(posedge CLOCK);
		chk("pclk runs", 32'h1, {31'h0, pk ^ LCD_PCLK});
		summarize();
	end
endmodule : tb_lcd_raster_timing_testcard
`default_nettype wire
